/* File: slice_map.svh */
// Constants for the slice arithmetic and wide selection fabric.
// Assumes inclusion by bare name from the package and the slice modules.
`ifndef SLICE_MAP_SVH
`define SLICE_MAP_SVH

`define SLICE_BITS          4
`define LUT_INPUTS          6
`define LUT_INIT_BITS       64
`define LUT_AUX_INPUTS      5
`define CARRY_ZERO_VALUE    1'h0
`define CARRY_ONE_VALUE     1'h1
`define SUM_RESET           4'h0
`define CARRY_RESET         4'h0
`define LUT_Q_RESET         4'h0
`define STORE_RESET         4'h0
`define ALT_RESET           1'h0
`define CASCADE_RESET       1'h0
`define PAIR_COUNT          2
`define QUAD_COUNT          1

`endif

/* File: slice_pkg.sv */
// Types shared by the slice modules.
// Assumes slice_map.svh is on the include path.
`include "slice_map.svh"

package slice_pkg;

  // Source of the carry into the lowest bit when a chain starts here
  typedef enum logic [1:0] {
    CARRY_INIT_ZERO,
    CARRY_INIT_ONE,
    CARRY_INIT_BYPASS
  } carry_init_type;

  // Source of each bit's generate term
  typedef enum logic {
    GEN_FROM_AUX,
    GEN_FROM_BYPASS
  } generate_src_type;

  // What the slice flip-flop of one bit stores
  typedef enum logic [1:0] {
    STORE_SUM,
    STORE_CARRY,
    STORE_LUT,
    STORE_BYPASS
  } store_src_type;

endpackage : slice_pkg

/* File: carry_chain.sv */
// Four-bit upward carry chain: per-bit carry select and sum xor.
// Assumes propagate and generate terms arrive from the same clock domain;
// purely combinational, registered by the caller.
`timescale 1ns/1ns

`include "slice_map.svh"

module carry_chain #(
  parameter int WIDTH = `SLICE_BITS
) (
  input  wire logic [WIDTH-1:0] propagate_in,
  input  wire logic [WIDTH-1:0] generate_in,
  input  wire logic             chain_first_carry_in,
  input  wire logic             slice_cascade_carry_in,
  input  wire logic             chain_start,
  output logic      [WIDTH-1:0] sum_out,
  output logic      [WIDTH-1:0] bit_carry_out
);

  logic carry_into_low;

  // A chain that begins here ignores the neighbour's carry
  assign carry_into_low = chain_start ? chain_first_carry_in
                                      : slice_cascade_carry_in;

  always_comb begin
    logic carry_in;
    carry_in = carry_into_low;
    sum_out = '0;
    bit_carry_out = '0;
    // Lowest bit first, each carry feeding the bit above
    for (int i = 0; i < WIDTH; i++) begin
      // Carry select mux and dedicated xor per bit
      sum_out[i] = propagate_in[i] ^ carry_in;
      bit_carry_out[i] = propagate_in[i] ? carry_in
                                         : generate_in[i];
      carry_in = bit_carry_out[i];
    end
  end

endmodule : carry_chain

/* File: logic_slice.sv */
// Logic slice: four function generators, carry chain, wide muxes, flops.
// Assumes all inputs come from fabric logic on core_clk; configuration
// inputs are held static while in use.
//
// What this block does
// - Carry chain four bits tall, carries run upward from lowest bit.
// - Each bit has one carry select mux and one dedicated xor gate.
// - Chain takes ten inputs and gives four sums and four bit carries.
// - Propagate of each bit comes from its generator's main output.
// - Generate picks auxiliary generator output or the bypass input.
// - First carry is constant 0, constant 1, or first bypass input.
// - Chain starting here uses first carry instead of cascade carry-in.
// - Top bit carry drives the slice cascade carry-out to next slice.
// - Sum outputs show each bit's sum, carry outputs each bit's carry.
// - Chain results can be captured in the slice flip-flops.
// - Carry path can chain generator outputs into wide logic functions.
// - Each generator can act as a 4:1 mux, outputs registrable.
// - Two pair muxes each join two generators into 8:1 selections.
// - One quad mux joins both pair muxes into one 16:1 selection.
// - No dedicated path for muxes wider than 16:1 between slices.
// - Pair results reach alternate outputs; quad result reaches one.
`timescale 1ns/1ns

`include "slice_map.svh"

module logic_slice #(
  parameter int BITS      = `SLICE_BITS,
  parameter int LUT_IN    = `LUT_INPUTS,
  parameter int LUT_INIT  = `LUT_INIT_BITS
) (
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  input  wire logic                         clk_en,
  input  wire logic [LUT_IN-1:0]            lut_addr_a,
  input  wire logic [LUT_IN-1:0]            lut_addr_b,
  input  wire logic [LUT_IN-1:0]            lut_addr_c,
  input  wire logic [LUT_IN-1:0]            lut_addr_d,
  input  wire logic [LUT_INIT-1:0]          lut_table_a,
  input  wire logic [LUT_INIT-1:0]          lut_table_b,
  input  wire logic [LUT_INIT-1:0]          lut_table_c,
  input  wire logic [LUT_INIT-1:0]          lut_table_d,
  input  wire logic                         first_bypass_in,
  input  wire logic                         second_bypass_in,
  input  wire logic                         third_bypass_in,
  input  wire logic                         fourth_bypass_in,
  input  wire logic                         slice_cascade_carry_in,
  input  wire logic                         chain_start,
  input  wire slice_pkg::carry_init_type    carry_init_mode,
  input  wire slice_pkg::generate_src_type  gen_src_a,
  input  wire slice_pkg::generate_src_type  gen_src_b,
  input  wire slice_pkg::generate_src_type  gen_src_c,
  input  wire slice_pkg::generate_src_type  gen_src_d,
  input  wire slice_pkg::store_src_type     store_src_a,
  input  wire slice_pkg::store_src_type     store_src_b,
  input  wire slice_pkg::store_src_type     store_src_c,
  input  wire slice_pkg::store_src_type     store_src_d,
  output logic      [BITS-1:0]              lut_main_q,
  output logic      [BITS-1:0]              sum_out,
  output logic      [BITS-1:0]              bit_carry_out,
  output logic                              slice_cascade_carry_out,
  output logic                              alt_out_first,
  output logic                              alt_out_second,
  output logic                              alt_out_third,
  output logic      [BITS-1:0]              store_q
);

  // Main output: full six-input lookup
  function automatic logic lut_main(input logic [LUT_INIT-1:0] table_bits,
                                    input logic [LUT_IN-1:0]   addr);
    lut_main = table_bits[addr];
  endfunction : lut_main

  // Auxiliary output: five-input function from the lower half of the table
  function automatic logic lut_aux(input logic [LUT_INIT-1:0] table_bits,
                                   input logic [LUT_IN-1:0]   addr);
    logic [LUT_IN-1:0] low_addr;
    low_addr = {1'h0, addr[`LUT_AUX_INPUTS-1:0]};
    lut_aux = table_bits[low_addr];
  endfunction : lut_aux

  // Generate term per bit
  function automatic logic pick_generate(
    input slice_pkg::generate_src_type src,
    input logic                        aux_bit,
    input logic                        bypass_bit);
    case (src)
      slice_pkg::GEN_FROM_AUX:    pick_generate = aux_bit;
      slice_pkg::GEN_FROM_BYPASS: pick_generate = bypass_bit;
      default:                    pick_generate = aux_bit;
    endcase
  endfunction : pick_generate

  // Carry into the lowest bit when a chain starts in this slice
  function automatic logic pick_first_carry(
    input slice_pkg::carry_init_type mode,
    input logic                      bypass_bit);
    case (mode)
      slice_pkg::CARRY_INIT_ZERO:   pick_first_carry = `CARRY_ZERO_VALUE;
      slice_pkg::CARRY_INIT_ONE:    pick_first_carry = `CARRY_ONE_VALUE;
      slice_pkg::CARRY_INIT_BYPASS: pick_first_carry = bypass_bit;
      default:                      pick_first_carry = `CARRY_ZERO_VALUE;
    endcase
  endfunction : pick_first_carry

  // Data input of one slice flip-flop
  function automatic logic pick_store(
    input slice_pkg::store_src_type src,
    input logic                     sum_bit,
    input logic                     carry_bit,
    input logic                     lut_bit,
    input logic                     bypass_bit);
    case (src)
      slice_pkg::STORE_SUM:    pick_store = sum_bit;
      slice_pkg::STORE_CARRY:  pick_store = carry_bit;
      slice_pkg::STORE_LUT:    pick_store = lut_bit;
      slice_pkg::STORE_BYPASS: pick_store = bypass_bit;
      // Unknown codes fall back to the sum, the common arithmetic use
      default:                 pick_store = sum_bit;
    endcase
  endfunction : pick_store

  // Generator inputs gathered so every bit is indexed the same way
  wire logic [LUT_INIT-1:0] table_of [BITS];
  wire logic [LUT_IN-1:0]   addr_of  [BITS];

  assign table_of[0] = lut_table_a;
  assign table_of[1] = lut_table_b;
  assign table_of[2] = lut_table_c;
  assign table_of[3] = lut_table_d;
  assign addr_of[0]  = lut_addr_a;
  assign addr_of[1]  = lut_addr_b;
  assign addr_of[2]  = lut_addr_c;
  assign addr_of[3]  = lut_addr_d;

  // Function generator results
  wire logic [BITS-1:0] main_out;
  wire logic [BITS-1:0] aux_out;
  wire logic [BITS-1:0] bypass_bits;

  // A 4:1 mux is a table whose data and select lines share the six inputs
  assign main_out[0] = lut_main(table_of[0], addr_of[0]);
  assign main_out[1] = lut_main(table_of[1], addr_of[1]);
  assign main_out[2] = lut_main(table_of[2], addr_of[2]);
  assign main_out[3] = lut_main(table_of[3], addr_of[3]);

  // Aux output reads the lower half of the table through five inputs
  assign aux_out[0]  = lut_aux(table_of[0], addr_of[0]);
  assign aux_out[1]  = lut_aux(table_of[1], addr_of[1]);
  assign aux_out[2]  = lut_aux(table_of[2], addr_of[2]);
  assign aux_out[3]  = lut_aux(table_of[3], addr_of[3]);

  assign bypass_bits[0] = first_bypass_in;
  assign bypass_bits[1] = second_bypass_in;
  assign bypass_bits[2] = third_bypass_in;
  assign bypass_bits[3] = fourth_bypass_in;

  // Carry chain operands
  wire logic [BITS-1:0] propagate_in;
  wire logic [BITS-1:0] generate_in;
  wire logic            chain_first_carry_in;

  assign propagate_in = main_out;

  // Aux output for multipliers, bypass for adders and accumulators
  assign generate_in[0] = pick_generate(gen_src_a, aux_out[0],
                                        bypass_bits[0]);
  assign generate_in[1] = pick_generate(gen_src_b, aux_out[1],
                                        bypass_bits[1]);
  assign generate_in[2] = pick_generate(gen_src_c, aux_out[2],
                                        bypass_bits[2]);
  assign generate_in[3] = pick_generate(gen_src_d, aux_out[3],
                                        bypass_bits[3]);

  // Zero for add, one for subtract, bypass for a run-time first carry;
  // the unused fourth mode code falls back to zero.
  assign chain_first_carry_in =
      pick_first_carry(carry_init_mode, first_bypass_in);

  wire logic [BITS-1:0] next_sum;
  wire logic [BITS-1:0] next_carry;

  // Ten inputs in, eight outputs back
  carry_chain #(
    .WIDTH (BITS)
  ) chain (
    .propagate_in           (propagate_in),
    .generate_in            (generate_in),
    .chain_first_carry_in   (chain_first_carry_in),
    .slice_cascade_carry_in (slice_cascade_carry_in),
    .chain_start            (chain_start),
    .sum_out                (next_sum),
    .bit_carry_out          (next_carry)
  );

  // Wide logic: with generate tied low and propagate as a table output, the
  // chain forms an AND of the four main outputs with the incoming carry.
  // No separate path is needed; the same chain serves it

  // Wide selection tree; selects reuse the bypass inputs as the fabric does
  wire logic lower_pair_sel;
  wire logic upper_pair_sel;
  wire logic quad_sel;
  wire logic lower_pair;
  wire logic upper_pair;
  wire logic quad_pick;

  // Borrowed selects cost no pins, but those bypass bits then feed both
  // their flop path and the tree; the user must keep the two uses apart.
  assign lower_pair_sel = first_bypass_in;
  assign upper_pair_sel = third_bypass_in;
  assign quad_sel       = second_bypass_in;

  // Each pair mux joins two generators into an 8:1 selection
  assign lower_pair = lower_pair_sel ? main_out[1]
                                     : main_out[0];
  assign upper_pair = upper_pair_sel ? main_out[3]
                                     : main_out[2];
  // Quad mux joins both pairs into the single 16:1 selection
  assign quad_pick  = quad_sel ? upper_pair
                               : lower_pair;
  // The quad result leaves only on alternate outputs; there is deliberately
  // no cascade port for it, so wider trees go through general routing.

  wire logic [BITS-1:0] next_store;

  assign next_store[0] = pick_store(store_src_a, next_sum[0], next_carry[0],
                                    main_out[0], bypass_bits[0]);
  assign next_store[1] = pick_store(store_src_b, next_sum[1], next_carry[1],
                                    main_out[1], bypass_bits[1]);
  assign next_store[2] = pick_store(store_src_c, next_sum[2], next_carry[2],
                                    main_out[2], bypass_bits[2]);
  assign next_store[3] = pick_store(store_src_d, next_sum[3], next_carry[3],
                                    main_out[3], bypass_bits[3]);

  // Every output is registered; the cascade thus costs a cycle per slice,
  // which trades chain latency for a clean flop-to-flop timing path.
  // Reset is tested before the enable so a frozen slice still clears.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sum_out <= `SUM_RESET;
    end else if (clk_en) begin
      sum_out <= next_sum;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bit_carry_out <= `CARRY_RESET;
    end else if (clk_en) begin
      bit_carry_out <= next_carry;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      slice_cascade_carry_out <= `CASCADE_RESET;
    end else if (clk_en) begin
      slice_cascade_carry_out <= next_carry[BITS-1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lut_main_q <= `LUT_Q_RESET;
    end else if (clk_en) begin
      lut_main_q <= main_out;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      store_q <= `STORE_RESET;
    end else if (clk_en) begin
      store_q <= next_store;
    end
  end

  // Pair results on the first and third outputs, the 16:1 result on second
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      alt_out_first <= `ALT_RESET;
    end else if (clk_en) begin
      alt_out_first <= lower_pair;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      alt_out_second <= `ALT_RESET;
    end else if (clk_en) begin
      alt_out_second <= quad_pick;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      alt_out_third <= `ALT_RESET;
    end else if (clk_en) begin
      alt_out_third <= upper_pair;
    end
  end

endmodule : logic_slice

/* File: slice_below_model.sv */
// Neighbouring slice below: its registered carry-out feeds our cascade in.
// Assumes the same clock, reset and clock enable as the slice under test.
`timescale 1ns/1ns

module slice_below_model (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic carry_seed,
  output logic      slice_cascade_carry_in
);
  // Registered like a real slice, so the carry lags its seed by one edge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      slice_cascade_carry_in <= 1'h0;
    end else if (clk_en) begin
      slice_cascade_carry_in <= carry_seed;
    end
  end
endmodule : slice_below_model

/* File: slice_carry_chain_and_wide_mux_props.sv */
// Assertions on the registered chain, mux and store outputs of the slice.
// Assumes slice_pkg is compiled first; bound into every logic_slice.
`timescale 1ns/1ns

module slice_checker_props (
  input wire logic                        core_clk,
  input wire logic                        resetn,
  input wire logic                        clk_en,
  input wire logic [5:0]                  lut_addr_a,
  input wire logic [5:0]                  lut_addr_b,
  input wire logic [5:0]                  lut_addr_c,
  input wire logic [5:0]                  lut_addr_d,
  input wire logic [63:0]                 lut_table_a,
  input wire logic [63:0]                 lut_table_b,
  input wire logic [63:0]                 lut_table_c,
  input wire logic [63:0]                 lut_table_d,
  input wire logic                        first_bypass_in,
  input wire logic                        second_bypass_in,
  input wire logic                        third_bypass_in,
  input wire logic                        fourth_bypass_in,
  input wire logic                        slice_cascade_carry_in,
  input wire logic                        chain_start,
  input wire slice_pkg::carry_init_type   carry_init_mode,
  input wire slice_pkg::generate_src_type gen_src_a,
  input wire slice_pkg::generate_src_type gen_src_b,
  input wire slice_pkg::generate_src_type gen_src_c,
  input wire slice_pkg::generate_src_type gen_src_d,
  input wire slice_pkg::store_src_type    store_src_a,
  input wire slice_pkg::store_src_type    store_src_b,
  input wire slice_pkg::store_src_type    store_src_c,
  input wire slice_pkg::store_src_type    store_src_d,
  input wire logic [3:0]                  lut_main_q,
  input wire logic [3:0]                  sum_out,
  input wire logic [3:0]                  store_q,
  input wire logic [3:0]                  bit_carry_out,
  input wire logic                        slice_cascade_carry_out,
  input wire logic                        alt_out_first,
  input wire logic                        alt_out_second,
  input wire logic                        alt_out_third
);
  logic [3:0]                  p, s, c, st;
  logic                        ci, g, lo7, up7;
  logic [19:0]                 all_q;
  logic [63:0]                 tv [4];
  logic [5:0]                  av [4];
  logic [3:0]                  bv;
  slice_pkg::generate_src_type gv [4];
  slice_pkg::store_src_type    sv [4];
  assign tv = '{lut_table_a, lut_table_b, lut_table_c, lut_table_d};
  assign av = '{lut_addr_a, lut_addr_b, lut_addr_c, lut_addr_d};
  assign gv = '{gen_src_a, gen_src_b, gen_src_c, gen_src_d};
  assign sv = '{store_src_a, store_src_b, store_src_c, store_src_d};
  assign bv = {fourth_bypass_in, third_bypass_in, second_bypass_in,
               first_bypass_in};
  assign lo7 = bv[0] ? p[1] : p[0];
  assign up7 = bv[2] ? p[3] : p[2];
  assign all_q = {lut_main_q, sum_out, bit_carry_out, store_q,
                  slice_cascade_carry_out, alt_out_first, alt_out_second,
                  alt_out_third};
  always_comb begin
    ci = !chain_start ? slice_cascade_carry_in :
         carry_init_mode == slice_pkg::CARRY_INIT_ZERO ? 1'h0 :
         carry_init_mode == slice_pkg::CARRY_INIT_ONE ? 1'h1 : bv[0];
    for (int i = 0; i < 4; i++) begin
      p[i] = tv[i][av[i]];
      g = gv[i] == slice_pkg::GEN_FROM_AUX ? tv[i][{1'h0, av[i][4:0]}]
                                           : bv[i];
      s[i] = p[i] ^ ci;
      c[i] = p[i] ? ci : g;
      ci = c[i];
      st[i] = sv[i] == slice_pkg::STORE_CARRY ? c[i] :
              sv[i] == slice_pkg::STORE_LUT ? p[i] :
              sv[i] == slice_pkg::STORE_BYPASS ? bv[i] : s[i];
    end
  end

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!resetn);

  main_out_a: assert property (
    clk_en |=> lut_main_q == $past(p)) else $error("main out wrong");
  sum_bits_a: assert property (
    clk_en |=> sum_out == $past(s)) else $error("sum wrong");
  carry_bits_a: assert property (
    clk_en |=> bit_carry_out == $past(c)) else $error("carry wrong");
  cascade_out_a: assert property (
    clk_en |=> slice_cascade_carry_out == $past(c[3]))
    else $error("cascade out wrong");
  lower_pair_a: assert property (
    clk_en |=> alt_out_first == $past(lo7)) else $error("lower pair");
  upper_pair_a: assert property (
    clk_en |=> alt_out_third == $past(up7)) else $error("upper pair");
  quad_sel_a: assert property (
    clk_en |=> alt_out_second == $past(bv[1] ? up7 : lo7))
    else $error("quad mux wrong");
  store_sel_a: assert property (
    clk_en |=> store_q == $past(st)) else $error("store wrong");
  hold_off_a: assert property (
    !clk_en |=> $stable(all_q)) else $error("outputs moved");
  reset_zero_a: assert property (
    disable iff (1'b0) !resetn |=> all_q == 20'h0)
    else $error("reset not clear");
endmodule : slice_checker_props

bind logic_slice slice_checker_props chk_u (.*);

/* File: test_slice_carry_chain_and_wide_mux.sv */
// Self-checking bench for the logic slice: random and corner stimulus.
// Assumes slice_pkg, logic_slice, its checker and the neighbour model.
`timescale 1ns/1ns

module test_slice_carry_chain_and_wide_mux;
  logic                        core_clk, resetn, clk_en, chain_start;
  logic                        carry_seed, slice_cascade_carry_in;
  logic [5:0]                  addr [4];
  logic [63:0]                 tbl [4];
  logic [3:0]                  byp, lut_main_q, sum_out, bit_carry_out;
  logic [3:0]                  store_q;
  logic                        slice_cascade_carry_out, alt_out_first;
  logic                        alt_out_second, alt_out_third;
  slice_pkg::carry_init_type   carry_init_mode;
  slice_pkg::generate_src_type gs [4];
  slice_pkg::store_src_type    ss [4];
  logic [18:0]                 pend, want;
  logic [15:0]                 lfsr, r;
  logic                        prev_rst, prev_en;
  int                          n_errors, comparisons;

  logic_slice dut_u (.core_clk, .resetn, .clk_en, .chain_start,
    .slice_cascade_carry_in, .carry_init_mode, .lut_main_q, .sum_out,
    .lut_addr_a(addr[0]), .lut_addr_b(addr[1]), .lut_addr_c(addr[2]),
    .lut_addr_d(addr[3]), .lut_table_a(tbl[0]), .lut_table_b(tbl[1]),
    .lut_table_c(tbl[2]), .lut_table_d(tbl[3]), .first_bypass_in(byp[0]),
    .second_bypass_in(byp[1]), .third_bypass_in(byp[2]),
    .fourth_bypass_in(byp[3]), .gen_src_a(gs[0]), .gen_src_b(gs[1]),
    .gen_src_c(gs[2]), .gen_src_d(gs[3]), .store_src_a(ss[0]),
    .store_src_b(ss[1]), .store_src_c(ss[2]), .store_src_d(ss[3]),
    .bit_carry_out, .slice_cascade_carry_out, .alt_out_first,
    .alt_out_second, .alt_out_third, .store_q);
  slice_below_model below_u (.core_clk, .resetn, .clk_en, .carry_seed,
    .slice_cascade_carry_in);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  // Packs main, sum, carry, store, then lower, quad and upper mux results
  function automatic logic [18:0] expect_out();
    logic [3:0] m, s, c, st;
    logic       ci, g;
    ci = !chain_start ? slice_cascade_carry_in :
         carry_init_mode == slice_pkg::CARRY_INIT_ZERO ? 1'h0 :
         carry_init_mode == slice_pkg::CARRY_INIT_ONE ? 1'h1 : byp[0];
    for (int i = 0; i < 4; i++) begin
      m[i] = tbl[i][addr[i]];
      g = gs[i] == slice_pkg::GEN_FROM_AUX ? tbl[i][{1'h0, addr[i][4:0]}]
                                           : byp[i];
      s[i] = m[i] ^ ci;
      c[i] = m[i] ? ci : g;
      ci = c[i];
      st[i] = ss[i] == slice_pkg::STORE_CARRY ? c[i] :
              ss[i] == slice_pkg::STORE_LUT ? m[i] :
              ss[i] == slice_pkg::STORE_BYPASS ? byp[i] : s[i];
    end
    return {m, s, c, st, byp[0] ? m[1] : m[0],
            byp[1] ? (byp[2] ? m[3] : m[2]) : (byp[0] ? m[1] : m[0]),
            byp[2] ? m[3] : m[2]};
  endfunction : expect_out

  task automatic check(string name, logic [3:0] exp, logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    lfsr = 16'h0642;
    {n_errors, comparisons} = '0;
    {resetn, chain_start, carry_seed, byp, prev_rst, prev_en} = '0;
    clk_en = 1'b1;
    {pend, want} = '0;
    carry_init_mode = slice_pkg::CARRY_INIT_ZERO;
    addr = '{4{6'h00}};
    tbl = '{4{64'h0}};
    gs = '{4{slice_pkg::GEN_FROM_AUX}};
    ss = '{4{slice_pkg::STORE_SUM}};
    for (int i = 0; i < 600; i++) begin
      @(negedge core_clk);
      // Cleared after reset, held while the clock enable was low
      if (!prev_rst) want = '0;
      else if (prev_en) want = pend;
      check("main", want[18:15], lut_main_q);
      check("sum", want[14:11], sum_out);
      check("carry", want[10:7], bit_carry_out);
      check("cascade", {3'h0, want[10]},
            {3'h0, slice_cascade_carry_out});
      check("store", want[6:3], store_q);
      check("alt", {1'h0, want[2:0]},
            {1'h0, alt_out_first, alt_out_second, alt_out_third});
      // Remember what the coming edge will see, for the next check
      resetn = i >= 2 && i != 300;
      clk_en = i % 7 != 5;
      prev_rst = resetn;
      prev_en = clk_en;
      // Batch 1 is full propagate, batch 2 pure generate
      if (i % 40 == 0) begin
        for (int k = 0; k < 4; k++) begin
          tbl[k] = i == 40 ? '1 : i == 80 ? '0
                                          : {rnd(), rnd(), rnd(), rnd()};
        end
      end
      for (int k = 0; k < 4; k++) begin
        r = rnd();
        addr[k] = r[5:0];
        gs[k] = slice_pkg::generate_src_type'(r[6]);
        ss[k] = slice_pkg::store_src_type'(2'(i + k));
        byp[k] = r[7];
      end
      chain_start = r[8];
      carry_seed = r[9];
      carry_init_mode = slice_pkg::carry_init_type'(2'(i % 3));
      pend = expect_out();
    end
    report_and_stop();
  end
endmodule : test_slice_carry_chain_and_wide_mux
